/* File: logic/svm_map.svh */
// Constants for the supply voltage monitor
`ifndef SVM_MAP_SVH
`define SVM_MAP_SVH
`define SVM_LEVEL_W 3
`define SVM_LEVEL_CNT 8
`define SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE 8
`define SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE_W 4
`define SVM_POR_HOLD_NS 64
`define SVM_CLK_NS 4
`define SVM_POR_HOLD_CYC ((`SVM_POR_HOLD_NS + `SVM_CLK_NS - 1) / `SVM_CLK_NS)
`define SVM_HOLD_W 5
`define SVM_FLAG_BIT 0
`endif

/* File: logic/svm_pkg.sv */
// Types for the supply voltage monitor
package svm_pkg;
  typedef enum logic [1:0] {
    SVM_ST_RESET,
    SVM_ST_RUN
  } svm_state_t;
  // Power control fields written by software
  typedef struct packed {
    logic [2:0] threshold_level_select;
    logic detector_enable;
  } svm_ctrl_t;
  // Event toward the external interrupt controller
  typedef struct packed {
    logic pulse;
    logic [3:0] line;
  } svm_event_t;
endpackage

/* File: logic/svm_sync.sv */
// Two flip-flop synchroniser for one vector of levels
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } svm_sync_state_t;
  svm_sync_state_t st_reg;
  svm_sync_state_t st_next;
  // First stage feeds only the second stage
  always_comb begin
    st_next.first = async_i;
    st_next.second = st_reg.first;
  end
  // Register both stages
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign sync_o = st_reg.second;
endmodule

/* File: logic/svm_top.sv */
// Supply voltage monitor control and status logic
// Operation
// - The supply is compared against the threshold picked by the select.
// - Each crossing either way raises an event on interrupt line 8.
// - The detector works only while its enable is set.
// - The flag reads 1 when the supply is below threshold, else 0.
// - Power-on and power-down comparators request system reset.
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire svm_pkg::svm_ctrl_t ctrl_i,
  input wire logic [`SVM_LEVEL_CNT-1:0] level_below_i,
  input wire logic por_below_i,
  input wire logic pdr_below_i,
  output logic supply_below_flag_o,
  output svm_pkg::svm_event_t event_o,
  output logic sys_reset_req_o
);
  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [`SVM_LEVEL_CNT+1:0] pins_sync;
  logic [`SVM_LEVEL_CNT+1:0] pins_raw;
  // Reset comparators above the level comparators
  assign pins_raw = {pdr_below_i, por_below_i, level_below_i};
  svm_sync #(
    .W(`SVM_LEVEL_CNT + 2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    svm_pkg::svm_state_t state;
    logic flag;
    logic pulse;
    logic reset_req;
    logic [`SVM_HOLD_W-1:0] hold;
  } svm_top_state_t;
  svm_top_state_t st_reg;
  svm_top_state_t st_next;
  logic cmp_below;
  logic supply_low;
  // Pick the comparator of the selected level
  assign cmp_below =
    pins_sync[ctrl_i.threshold_level_select];
  // Either reset comparator asks for reset
  assign supply_low = pins_sync[`SVM_LEVEL_CNT] |
    pins_sync[`SVM_LEVEL_CNT+1];
  // Next state: flag, crossing event and reset stretch
  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    case (st_reg.state)
      svm_pkg::SVM_ST_RESET: begin
        st_next.reset_req = 1'b1;
        st_next.flag = 1'b0;
        if (supply_low) begin
          st_next.hold = '0;
        end else if (st_reg.hold ==
          `SVM_HOLD_W'(`SVM_POR_HOLD_CYC - 1)) begin
          st_next.state = svm_pkg::SVM_ST_RUN;
          st_next.reset_req = 1'b0;
        end else begin
          st_next.hold = st_reg.hold + `SVM_HOLD_W'(1);
        end
      end
      svm_pkg::SVM_ST_RUN: begin
        if (supply_low) begin
          st_next.state = svm_pkg::SVM_ST_RESET;
          st_next.reset_req = 1'b1;
          st_next.hold = '0;
          st_next.flag = 1'b0;
        end else if (ctrl_i.detector_enable) begin
          st_next.flag = cmp_below;
          st_next.pulse = cmp_below ^ st_reg.flag;
        end else begin
          st_next.flag = 1'b0;
        end
      end
      default: begin
        st_next.state = svm_pkg::SVM_ST_RESET;
      end
    endcase
  end
  // Register the whole state
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.state <= svm_pkg::SVM_ST_RESET;
      st_reg.reset_req <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // Flag, pulse and reset request straight from flip-flops; event line is a constant
  assign supply_below_flag_o = st_reg.flag;
  assign event_o.pulse = st_reg.pulse;
  assign event_o.line = `SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE_W'(`SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE);
  assign sys_reset_req_o = st_reg.reset_req;
  // ==========================================================
  // Assertions
  // ==========================================================
  // Flag tracks the selected comparator one edge later
  property p_sel_follow;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (st_reg.state == svm_pkg::SVM_ST_RUN && !supply_low &&
     ctrl_i.detector_enable) |=> (supply_below_flag_o == $past(cmp_below));
  endproperty
  a_sel_follow: assert property (p_sel_follow)
    else $error("flag does not follow selected level");
  // Any flag move while enabled and out of reset is an event
  property p_edge_event;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(supply_below_flag_o) && sys_reset_req_o == 1'b0 &&
    $past(sys_reset_req_o) == 1'b0 && $past(ctrl_i.detector_enable) |->
    event_o.pulse;
  endproperty
  a_edge_event: assert property (p_edge_event)
    else $error("crossing without event");
  // Events carry the fixed line and only come with a flag move
  property p_event_line;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    event_o.pulse |-> event_o.line == `SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE_W'(`SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE) &&
      !$stable(supply_below_flag_o);
  endproperty
  a_event_line: assert property (p_event_line)
    else $error("event wrong line or spurious");
  // Disabled detector keeps the flag low and stays silent
  property p_disabled;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !ctrl_i.detector_enable |=> !supply_below_flag_o && !event_o.pulse;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("detector active while disabled");
  // A set flag needs an enabled detector and a low comparator
  property p_flag_val;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    supply_below_flag_o |-> $past(cmp_below) && $past(ctrl_i.detector_enable);
  endproperty
  a_flag_val: assert property (p_flag_val)
    else $error("flag set while supply above");
  // Low supply holds the reset request for at least two edges
  sequence s_low;
    supply_low;
  endsequence
  sequence s_reset_held;
    sys_reset_req_o [*2];
  endsequence
  property p_reset;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_low |=> s_reset_held;
  endproperty
  a_reset: assert property (p_reset)
    else $error("no reset on low supply");
  // Flag holds while its inputs hold
  property p_flag_stable;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $past(cmp_below) == cmp_below && $stable(ctrl_i) && !supply_low &&
    $past(st_reg.state) == svm_pkg::SVM_ST_RUN &&
    st_reg.state == svm_pkg::SVM_ST_RUN |=> $stable(supply_below_flag_o);
  endproperty
  a_flag_stable: assert property (p_flag_stable)
    else $error("flag moved without comparator change");
  // Request drops only at the end of the stretch
  property p_release;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sys_reset_req_o) |-> $past(st_reg.hold) ==
      `SVM_HOLD_W'(`SVM_POR_HOLD_CYC - 1);
  endproperty
  a_release: assert property (p_release)
    else $error("reset released early");
  // ==========================================================
  // Assertions on reset stretch, event direction and synchroniser
  // ==========================================================
  // No flag and no event while reset is requested
  property p_reset_quiet;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    sys_reset_req_o |-> !supply_below_flag_o && !event_o.pulse;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("flag or event during reset request");
  // Stretch counter steps by one while supplies are fine
  sequence s_counting;
    st_reg.state == svm_pkg::SVM_ST_RESET && !supply_low &&
    st_reg.hold != `SVM_HOLD_W'(`SVM_POR_HOLD_CYC - 1);
  endsequence
  property p_hold_step;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_counting |=> sys_reset_req_o &&
      st_reg.hold == $past(st_reg.hold) + `SVM_HOLD_W'(1);
  endproperty
  a_hold_step: assert property (p_hold_step)
    else $error("reset stretch counter skipped");
  // A low supply restarts the stretch from zero
  property p_low_restart;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    supply_low |=> st_reg.hold == '0 &&
      st_reg.state == svm_pkg::SVM_ST_RESET;
  endproperty
  a_low_restart: assert property (p_low_restart)
    else $error("stretch not restarted by low supply");
  // A low supply clears the flag on the next edge
  property p_low_flag;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    supply_low |=> !supply_below_flag_o;
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("flag kept under low supply");
  // Request low only while running
  property p_run_release;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_reset_req_o |-> st_reg.state == svm_pkg::SVM_ST_RUN;
  endproperty
  a_run_release: assert property (p_run_release)
    else $error("reset request low outside run");
  // Event points the way the comparator moved
  property p_event_dir;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    event_o.pulse |-> supply_below_flag_o == $past(cmp_below) &&
      $past(ctrl_i.detector_enable);
  endproperty
  a_event_dir: assert property (p_event_dir)
    else $error("event does not match comparator");
  // Pins reach the logic exactly two edges late
  property p_sync_delay;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
      pins_sync == $past(pins_raw, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser latency wrong");
endmodule

/* File: testbench/svm_irq_model.sv */
// Interrupt controller stand-in counting detector events
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_irq_model (
  input wire logic core_clk_i,
  input wire svm_pkg::svm_event_t event_i,
  output int hits_o = 0,
  output int stray_o = 0
);
  // Count pulses on the detector line and on any other line
  always @(posedge core_clk_i) begin
    if (event_i.pulse === 1'b1) begin
      if (event_i.line === `SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE_W'(`SVM_EXTERNAL_INTERRUPT_CONTROLLER_LINE)) begin
        hits_o <= hits_o + 1;
      end
      else stray_o <= stray_o + 1;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the supply voltage monitor
`timescale 1ns/10ps
`include "svm_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic core_clk_i;
  logic sys_rst_i;
  svm_pkg::svm_ctrl_t ctrl;
  svm_pkg::svm_ctrl_t c;
  logic [`SVM_LEVEL_CNT-1:0] below;
  logic por_below;
  logic pdr_below;
  logic flag;
  svm_pkg::svm_event_t evt;
  logic rst_req;
  logic exp_flag;
  logic new_flag;
  int hits;
  int stray;
  int prev_hits;
  int new_evt;
  int vdd;
  int failures = 0;
  int compares = 0;
  int seed = 47870;
  // ==================
  // Design and partner
  svm_top i_dut (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ctrl_i(ctrl),
    .level_below_i(below),
    .por_below_i(por_below),
    .pdr_below_i(pdr_below),
    .supply_below_flag_o(flag),
    .event_o(evt),
    .sys_reset_req_o(rst_req)
  );
  svm_irq_model i_irq (
    .core_clk_i(core_clk_i),
    .event_i(evt),
    .hits_o(hits),
    .stray_o(stray)
  );
  // ==================
  // Helpers
  // Comparator pattern for supply step v; step n sits below level n
  function automatic logic [7:0] levels(input int v);
    for (int n = 0; n < 8; n++) levels[n] = (v <= n);
  endfunction
  // Expected flag for a control setting and supply step
  function automatic logic want(input svm_pkg::svm_ctrl_t k, input int v);
    logic [7:0] l;
    l = levels(v);
    return k.detector_enable & l[k.threshold_level_select];
  endfunction
  // Report counts and end the run
  task automatic give_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for the reset request to drop after exp_n edges
  task automatic wait_release(input int exp_n);
    int n;
    n = 0;
    while (rst_req !== 1'b0 && n < 40) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    `CHK(rst_req, 1'b0)
    `CHK(n, exp_n)
    if (rst_req !== 1'b0) give_verdict();
  endtask
  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    ctrl = 4'h0;
    c = 4'h0;
    below = 8'h00;
    por_below = 1'b0;
    pdr_below = 1'b0;
    vdd = 8;
    exp_flag = 1'b0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    `CHK(rst_req, 1'b1)
    wait_release(`SVM_POR_HOLD_CYC - 1);
    // Level boundaries per select first, then random steps
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk_i);
      if (i < 24) begin
        if (i % 3 == 0) c = {3'(i / 3), 1'b1};
        else vdd = i / 3 + i % 3 - 1;
      end else if ($random(seed) & 1) c = 4'($random(seed));
      else vdd = ($random(seed) & 15) % 9;
      ctrl <= c;
      below <= levels(vdd);
      prev_hits = hits;
      new_flag = want(c, vdd);
      // Disabling drops the flag silently
      new_evt = int'(new_flag != exp_flag && c.detector_enable);
      repeat (6) @(posedge core_clk_i);
      #1;
      `CHK(flag, new_flag)
      `CHK(hits - prev_hits, new_evt)
      exp_flag = new_flag;
    end
    // Power-down then power-on comparator forcing reset
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      if (k == 0) pdr_below <= 1'b1;
      else por_below <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      #1;
      `CHK({rst_req, flag}, 2'h2)
      @(posedge core_clk_i);
      pdr_below <= 1'b0;
      por_below <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      #1;
      `CHK(rst_req, 1'b1)
      // Two sync edges plus the stretch, ten edges already waited
      wait_release(`SVM_POR_HOLD_CYC + 2 - 10);
      // Flag comes back one edge after the request drops
      @(posedge core_clk_i);
      #1;
      `CHK(flag, want(c, vdd))
    end
    `CHK(stray, 0)
    give_verdict();
  end
endmodule
